//--- rtl/access_page_classifier.sv
// access-page exit classifier with apb control registers
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module access_page_classifier
    import access_page_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              acc_valid,
    input  wire logic [31:0]       acc_addr,
    input  wire logic [31:0]       acc_gpa,
    input  wire src_t              acc_src,
    input  wire logic              acc_slt_used,
    input  wire logic [1:0]        acc_leaf_level,
    input  wire logic [7:0]        acc_leaf_attr,
    input  wire logic              acc_slt_violation,
    input  wire logic              acc_fetch,
    input  wire logic              acc_write,
    input  wire logic [3:0]        acc_bytes,
    output logic                   res_valid,
    output class_t                 res_class,
    output logic                   res_exit,
    output prio_t                  res_prio,
    output logic                   res_memory_op,
    output logic                   res_write_before_exit,
    output logic                   res_tpr_shadow,
    output logic                   res_slt_violation,
    output logic                   slt_effective,
    output logic                   pae_active
);

    logic [6:0]       ctrl_r;
    logic [31:0]      primary_r;
    logic [2:0]       paging_r;
    logic [19:0]      page_base_r;
    logic [31:0]      root_r;
    logic [31:0]      inv_desc_r;
    logic             stale_vld_r;
    logic [19:0]      stale_gpa_r;
    logic [31:0]      stale_root_r;
    logic [CNT_W-1:0] exit_cnt_r;
    class_t           last_class_r;
    logic             last_exit_r;

    // ---------------- apb slave ----------------
    // pready is registered from the setup cycle and is high in the first access cycle, so every access phase lasts one cycle
    logic apb_setup;
    logic apb_write;
    logic known_addr;
    logic inv_single;
    logic inv_all;
    logic [31:0] ctrl_wr, paging_wr, base_wr;
    assign ctrl_wr   = merge({25'h0000000, ctrl_r}, pwdata, pstrb);
    assign paging_wr = merge({29'h00000000, paging_r}, pwdata, pstrb);
    assign base_wr   = merge({page_base_r, 12'h000}, pwdata, pstrb);
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pready & pwrite;
    assign inv_single = apb_write & (paddr[7:0] == OFS_INV_CMD) & pwdata[INV_SINGLE_BIT];
    assign inv_all = apb_write & (paddr[7:0] == OFS_INV_CMD) & pwdata[INV_ALL_BIT];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return m;
    endfunction

    always_comb begin
        known_addr = 1'b0;
        if (paddr[31:8] == 24'h000000 && paddr[1:0] == 2'h0 && paddr[7:0] <= OFS_EXIT_COUNT) begin
            known_addr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~known_addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            if (paddr[7:0] == OFS_CTRL) begin
                prdata <= {25'h0000000, ctrl_r};
            end else if (paddr[7:0] == OFS_PRIMARY) begin
                prdata <= primary_r;
            end else if (paddr[7:0] == OFS_PAGING) begin
                prdata <= {29'h00000000, paging_r};
            end else if (paddr[7:0] == OFS_PAGE_BASE) begin
                prdata <= {page_base_r, 12'h000};
            end else if (paddr[7:0] == OFS_ROOT) begin
                prdata <= root_r;
            end else if (paddr[7:0] == OFS_INV_DESC) begin
                prdata <= inv_desc_r;
            end else if (paddr[7:0] == OFS_STATUS) begin
                prdata <= {26'h0000000, pae_active, slt_effective, stale_vld_r,
                           last_exit_r, last_class_r};
            end else if (paddr[7:0] == OFS_EXIT_COUNT) begin
                prdata <= 32'(exit_cnt_r);
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else if (apb_setup) begin
            prdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
            primary_r <= PRIMARY_RESET;
            paging_r <= 3'h0;
            page_base_r <= 20'h00000;
            root_r <= 32'h0000_0000;
            inv_desc_r <= 32'h0000_0000;
        end else if (apb_write) begin
            if (paddr[7:0] == OFS_CTRL) begin
                ctrl_r <= ctrl_wr[6:0];
            end else if (paddr[7:0] == OFS_PRIMARY) begin
                primary_r <= merge(primary_r, pwdata, pstrb);
            end else if (paddr[7:0] == OFS_PAGING) begin
                paging_r <= paging_wr[2:0];
            end else if (paddr[7:0] == OFS_PAGE_BASE) begin
                page_base_r <= base_wr[31:12];
            end else if (paddr[7:0] == OFS_ROOT) begin
                root_r <= merge(root_r, pwdata, pstrb);
            end else if (paddr[7:0] == OFS_INV_DESC) begin
                inv_desc_r <= merge(inv_desc_r, pwdata, pstrb);
            end
        end
    end

    // ---------------- classification ----------------
    logic slt_on;
    logic pae_on;
    logic on_page;
    logic guest_phys;
    logic physical;
    logic linear;
    logic large_leaf;
    logic stale_hit;
    logic tpr_hit;
    logic may_omit;
    logic exit_nxt;

    assign slt_on = ctrl_r[CTRL_SLT_BIT] & primary_r[PRIMARY_SECONDARY_BIT];
    assign pae_on = paging_r[PAGING_PG_BIT] & paging_r[PAGING_PAE_BIT]
                  & ~paging_r[PAGING_LMA_BIT];
    assign on_page = ctrl_r[CTRL_VIRT_BIT] & (acc_addr[31:12] == page_base_r);

    // a source that by its nature never uses the translation of its own address
    function automatic logic phys_source(input src_t s, input logic slt, input logic extended_32bit_paging);
        case (s)
            SRC_PAGING_READ:     return ~slt;
            SRC_FLAG_UPDATE:     return ~slt;
            SRC_TOP_ENTRY_LOAD:  return ~slt & extended_32bit_paging;
            SRC_SLT_STRUCT:      return slt;
            SRC_CTRL_REGION:     return 1'b1;
            SRC_CTRL_REFERENCED: return 1'b1;
            SRC_MM_TRANSITION:   return 1'b1;
            default:             return 1'b0;
        endcase
    endfunction

    always_comb begin
        linear = acc_src == SRC_OWN_LINEAR;
        guest_phys = paging_r[PAGING_PG_BIT] & slt_on & acc_slt_used & ~linear
                   & ~phys_source(acc_src, slt_on, pae_on);
        physical = ~linear & ~guest_phys
                 & ((~slt_on | ~acc_slt_used) | phys_source(acc_src, slt_on, pae_on));
    end

    // large leaves: bit 7 of a level-3 or level-2 entry marks a 1-GByte or 2-MByte page
    assign large_leaf = acc_leaf_attr[LARGE_PAGE_BIT]
                      & ((acc_leaf_level == LEVEL_1GB) | (acc_leaf_level == LEVEL_2MB));
    assign stale_hit = stale_vld_r & (stale_gpa_r == acc_gpa[31:12])
                     & (stale_root_r == root_r);
    assign tpr_hit = ctrl_r[CTRL_TPR_BIT] & ~acc_fetch & (acc_bytes <= TPR_MAX_BYTES)
                   & (acc_addr[11:0] == TPR_OFFSET);

    // optional omissions are off after reset, so by default neither a large leaf nor a stale hit skips the exit
    assign may_omit = (ctrl_r[CTRL_OMIT_LARGE_BIT] & large_leaf)
                    | (ctrl_r[CTRL_OMIT_STALE_BIT] & stale_hit);

    always_comb begin
        exit_nxt = 1'b0;
        if (!acc_valid || !on_page) begin
            exit_nxt = 1'b0;
        end else if (guest_phys) begin
            exit_nxt = ~acc_slt_violation & ~may_omit & ~tpr_hit;
        end else if (physical) begin
            exit_nxt = ctrl_r[CTRL_PHYS_EXIT_BIT];
        end else if (linear) begin
            exit_nxt = ~acc_slt_violation & ~tpr_hit;
        end
    end

    // one-entry memory of a translation that led off the page under the current root
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stale_vld_r <= 1'b0;
            stale_gpa_r <= 20'h00000;
            stale_root_r <= 32'h0000_0000;
        end else if (acc_valid && guest_phys && !on_page) begin
            // a fill in the same cycle as an invalidate wins, matching a later walk
            stale_vld_r <= 1'b1;
            stale_gpa_r <= acc_gpa[31:12];
            stale_root_r <= root_r;
        end else if (inv_all || (inv_single && inv_desc_r == stale_root_r)) begin
            stale_vld_r <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid <= 1'b0;
            res_class <= CLASS_NONE;
            res_exit <= 1'b0;
            res_prio <= PRIO_NONE;
            res_memory_op <= 1'b0;
            res_write_before_exit <= 1'b0;
            res_tpr_shadow <= 1'b0;
            res_slt_violation <= 1'b0;
        end else begin
            res_valid <= acc_valid;
            res_exit <= exit_nxt;
            res_slt_violation <= acc_valid & acc_slt_violation;
            res_tpr_shadow <= acc_valid & on_page & tpr_hit & ~exit_nxt;
            // an on-page access that neither exits, hits the shadow offset nor has a violation reaches plain memory
            res_memory_op <= acc_valid & on_page & ~exit_nxt & ~tpr_hit
                           & ~acc_slt_violation;
            res_write_before_exit <= exit_nxt & physical & acc_write
                                   & ctrl_r[CTRL_WRITE_1ST_BIT];
            if (!acc_valid) begin
                res_class <= CLASS_NONE;
                res_prio <= PRIO_NONE;
            end else if (guest_phys) begin
                res_class <= CLASS_GUEST_PHYS;
                res_prio <= exit_nxt ? PRIO_AS_SLT_VIOLATION : PRIO_NONE;
            end else if (physical) begin
                res_class <= CLASS_PHYSICAL;
                res_prio <= exit_nxt ? PRIO_UNORDERED : PRIO_NONE;
            end else begin
                res_class <= CLASS_LINEAR;
                res_prio <= exit_nxt ? PRIO_AS_PAGE_FAULT : PRIO_NONE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slt_effective <= 1'b0;
            pae_active <= 1'b0;
        end else begin
            slt_effective <= slt_on;
            pae_active <= pae_on;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exit_cnt_r <= '0;
            last_class_r <= CLASS_NONE;
            last_exit_r <= 1'b0;
        end else if (acc_valid) begin
            exit_cnt_r <= exit_cnt_r + CNT_W'(exit_nxt);
            last_exit_r <= exit_nxt;
            last_class_r <= guest_phys ? CLASS_GUEST_PHYS :
                            physical ? CLASS_PHYSICAL : CLASS_LINEAR;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_gp_request;
        acc_valid && guest_phys && on_page;
    endsequence

    sequence s_gp_violation;
        s_gp_request ##0 acc_slt_violation;
    endsequence

    a_violation_blocks_exit: assert property (
        s_gp_violation |=> !res_exit && res_slt_violation && res_class == CLASS_GUEST_PHYS)
        else $error("page exit raised despite translation violation");

    a_no_exit_memory: assert property (
        acc_valid && on_page && !tpr_hit && !acc_slt_violation |=> res_exit != res_memory_op)
        else $error("non-exiting page access not sent to memory");

    a_gp_exit_priority: assert property (
        res_exit && res_class == CLASS_GUEST_PHYS |-> res_prio == PRIO_AS_SLT_VIOLATION)
        else $error("guest-physical exit priority wrong");

    a_bit31_gates_slt: assert property (
        !primary_r[PRIMARY_SECONDARY_BIT] |=> !slt_effective)
        else $error("translation active with primary bit 31 clear");

    a_pae_mode_check: assert property (
        ##1 pae_active == $past(paging_r[PAGING_PG_BIT] && paging_r[PAGING_PAE_BIT]
                                && !paging_r[PAGING_LMA_BIT]))
        else $error("extended paging flag wrong");

    a_tpr_offset_only: assert property (
        acc_valid && acc_addr[11:0] != TPR_OFFSET |=> !res_tpr_shadow)
        else $error("shadow access at wrong offset");

    a_tpr_width_limit: assert property (
        acc_valid && (acc_bytes > TPR_MAX_BYTES || acc_fetch) |=> !res_tpr_shadow)
        else $error("wide or fetch access taken as shadow");

    a_physical_slt_off: assert property (
        acc_valid && !slt_on && acc_src inside {SRC_PAGING_READ, SRC_FLAG_UPDATE}
        |=> res_class == CLASS_PHYSICAL)
        else $error("walk access not classified physical");

    a_invalidate_flush: assert property (
        inv_all && !(acc_valid && guest_phys && !on_page) |=> !stale_vld_r)
        else $error("cached translation survived invalidate");

    a_large_omit_policy: assert property (
        s_gp_request ##0 !acc_slt_violation && !tpr_hit && !may_omit |=> res_exit)
        else $error("guest-physical exit missing");

    a_phys_exit_policy: assert property (
        acc_valid && physical && on_page |=> res_exit == $past(ctrl_r[CTRL_PHYS_EXIT_BIT]))
        else $error("physical exit not following policy");

    a_apb_one_wait: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

endmodule
`default_nettype wire

//--- rtl/access_page_pkg.sv
// constants and types for the access-page exit classifier
//
// Behaviour
// - 1-GByte level-3 leaf may skip the exit
// - 2-MByte level-2 leaf may skip the exit
// - stale off-page cached translation may skip exit
// - no exit, no shadow access, no violation: access goes to memory
// - invalidate all or matching root flushes cache
// - translation violation suppresses the page exit
// - guest-physical exit ranks like translation violation
// - no translation use, no own linear: physical
// - translation off: walks, top entries, flags physical
// - translation on: its own structures are physical
// - control region and referenced structures are physical
// - management-mode entry, return, exits are physical
// - physical access exit is optional
// - physical write may complete before the exit
// - physical exit priority is left undefined
// - shadow access: enabled, no fetch, small, 80H
// - any other start offset is no shadow access
// - shadow accesses skip exit, physical ones may not
// - primary control bit 31 clear disables translation
// - extended 32-bit paging: paging, extension, not long
// - guest-physical: translated, not own linear translation
package access_page_pkg;

    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_PRIMARY    = 8'h04;
    localparam logic [7:0]  OFS_PAGING     = 8'h08;
    localparam logic [7:0]  OFS_PAGE_BASE  = 8'h0c;
    localparam logic [7:0]  OFS_ROOT       = 8'h10;
    localparam logic [7:0]  OFS_INV_DESC   = 8'h14;
    localparam logic [7:0]  OFS_INV_CMD    = 8'h18;
    localparam logic [7:0]  OFS_STATUS     = 8'h1c;
    localparam logic [7:0]  OFS_EXIT_COUNT = 8'h20;

    // control register fields
    localparam int CTRL_VIRT_BIT       = 0;
    localparam int CTRL_SLT_BIT        = 1;
    localparam int CTRL_TPR_BIT        = 2;
    localparam int CTRL_OMIT_LARGE_BIT = 3;
    localparam int CTRL_OMIT_STALE_BIT = 4;
    localparam int CTRL_PHYS_EXIT_BIT  = 5;
    localparam int CTRL_WRITE_1ST_BIT  = 6;
    localparam logic [6:0] CTRL_RESET  = 7'h60;
    localparam int PRIMARY_SECONDARY_BIT = 31;
    localparam logic [31:0] PRIMARY_RESET = 32'h0000_0000;
    localparam int PAGING_PG_BIT  = 0;
    localparam int PAGING_PAE_BIT = 1;
    localparam int PAGING_LMA_BIT = 2;
    localparam int INV_SINGLE_BIT = 0;
    localparam int INV_ALL_BIT    = 1;

    localparam int          LARGE_PAGE_BIT = 7;
    localparam logic [1:0]  LEVEL_2MB      = 2'h2;
    localparam logic [1:0]  LEVEL_1GB      = 2'h3;
    localparam logic [11:0] TPR_OFFSET     = 12'h080;
    localparam logic [3:0]  TPR_MAX_BYTES  = 4'h4;

    typedef enum logic [3:0] {
        SRC_OWN_LINEAR, SRC_NO_LINEAR, SRC_PAGING_READ, SRC_TOP_ENTRY_LOAD,
        SRC_FLAG_UPDATE, SRC_SLT_STRUCT, SRC_CTRL_REGION, SRC_CTRL_REFERENCED,
        SRC_MM_TRANSITION
    } src_t;

    typedef enum logic [1:0] {
        CLASS_NONE, CLASS_LINEAR, CLASS_GUEST_PHYS, CLASS_PHYSICAL
    } class_t;

    typedef enum logic [1:0] {
        PRIO_NONE, PRIO_AS_SLT_VIOLATION, PRIO_AS_PAGE_FAULT, PRIO_UNORDERED
    } prio_t;

endpackage

//--- verification/access_source.sv
// behavioural source of memory accesses presented to the classifier
`timescale 1ns/10ps
`default_nettype none
module access_source
    import access_page_pkg::*;
(
    input  wire logic  pclk,
    output logic       acc_valid,
    output logic [31:0] acc_addr,
    output logic [31:0] acc_gpa,
    output src_t       acc_src,
    output logic       acc_slt_used,
    output logic [1:0] acc_leaf_level,
    output logic [7:0] acc_leaf_attr,
    output logic       acc_slt_violation,
    output logic       acc_fetch,
    output logic       acc_write,
    output logic [3:0] acc_bytes
);
    initial begin
        acc_valid = 1'b0;
        acc_src = SRC_OWN_LINEAR;
        {acc_addr, acc_gpa, acc_slt_used, acc_leaf_level, acc_leaf_attr} = '0;
        {acc_slt_violation, acc_fetch, acc_write, acc_bytes} = '0;
    end

    // one access per call; address, guest address and leaf attributes flip once the pulse ends so a stale value
    // can never pass for a fresh request
    task automatic send(input src_t s, input logic [31:0] a, input logic [31:0] g,
                        input logic u, input logic [1:0] lv, input logic [7:0] at,
                        input logic v, input logic f, input logic w, input logic [3:0] b);
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_src   <= s;
        {acc_addr, acc_gpa, acc_slt_used, acc_leaf_level, acc_leaf_attr} <= {a, g, u, lv, at};
        {acc_slt_violation, acc_fetch, acc_write, acc_bytes} <= {v, f, w, b};
        @(posedge pclk);
        acc_valid <= 1'b0;
        {acc_addr, acc_gpa, acc_leaf_attr} <= ~{a, g, at};
    endtask
endmodule
`default_nettype wire

//--- verification/test_access_page_classifier.sv
// self-checking bench for the access-page exit classifier
`timescale 1ns/10ps
`default_nettype none
module test_access_page_classifier
    import access_page_pkg::*;
;
    typedef struct packed {
        logic   cc;
        logic   cm;
        class_t cls;
        logic   ex;
        prio_t  pr;
        logic   mem;
        logic   tpr;
        logic   wb;
    } exp_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0]  pstrb = 4'hf;
    wire  logic [31:0] prdata;
    wire  logic  pready, pslverr, acc_valid, acc_slt_used, acc_slt_violation, acc_fetch;
    wire  logic  acc_write, res_valid, res_exit, res_memory_op, res_write_before_exit;
    wire  logic  res_tpr_shadow, res_slt_violation, slt_effective, pae_active;
    wire  logic [31:0] acc_addr, acc_gpa;
    wire  src_t  acc_src;
    wire  logic [1:0] acc_leaf_level;
    wire  logic [7:0] acc_leaf_attr;
    wire  logic [3:0] acc_bytes;
    wire  class_t res_class;
    wire  prio_t res_prio;
    exp_t        exp_q[$];
    exp_t        e;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [31:0] ctrl, prim, pgr, base, rd, g, a;
    logic        err;

    always #10 pclk = ~pclk;

    access_page_classifier u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .acc_gpa(acc_gpa), .acc_src(acc_src),
        .acc_slt_used(acc_slt_used), .acc_leaf_level(acc_leaf_level),
        .acc_leaf_attr(acc_leaf_attr), .acc_slt_violation(acc_slt_violation),
        .acc_fetch(acc_fetch), .acc_write(acc_write), .acc_bytes(acc_bytes),
        .res_valid(res_valid), .res_class(res_class), .res_exit(res_exit),
        .res_prio(res_prio), .res_memory_op(res_memory_op),
        .res_write_before_exit(res_write_before_exit), .res_tpr_shadow(res_tpr_shadow),
        .res_slt_violation(res_slt_violation), .slt_effective(slt_effective),
        .pae_active(pae_active));

    access_source u_src (.pclk(pclk), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_gpa(acc_gpa), .acc_src(acc_src), .acc_slt_used(acc_slt_used),
        .acc_leaf_level(acc_leaf_level), .acc_leaf_attr(acc_leaf_attr),
        .acc_slt_violation(acc_slt_violation), .acc_fetch(acc_fetch),
        .acc_write(acc_write), .acc_bytes(acc_bytes));

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; the request is held until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic exp_t calc(src_t s, logic [31:0] ad, logic u, logic [1:0] lv,
                                  logic [7:0] at, logic v, logic f, logic w, logic [3:0] b,
                                  logic om);
        exp_t r;
        logic on, gp, tp;
        on = ctrl[CTRL_VIRT_BIT] && ad[31:12] == base[31:12];
        gp = pgr[0] && ctrl[CTRL_SLT_BIT] && prim[31] && u && s != SRC_OWN_LINEAR &&
             !(s inside {SRC_SLT_STRUCT, SRC_CTRL_REGION, SRC_CTRL_REFERENCED, SRC_MM_TRANSITION});
        r.cls = s == SRC_OWN_LINEAR ? CLASS_LINEAR : gp ? CLASS_GUEST_PHYS : CLASS_PHYSICAL;
        tp = on && ctrl[CTRL_TPR_BIT] && !f && b <= TPR_MAX_BYTES && ad[11:0] == TPR_OFFSET;
        om = om || (ctrl[CTRL_OMIT_LARGE_BIT] && at[LARGE_PAGE_BIT] && lv >= LEVEL_2MB);
        r.ex = on && (r.cls == CLASS_PHYSICAL ? ctrl[CTRL_PHYS_EXIT_BIT] : !v && !tp && !(gp && om));
        r.pr = !r.ex ? PRIO_NONE : r.cls == CLASS_PHYSICAL ? PRIO_UNORDERED :
               gp ? PRIO_AS_SLT_VIOLATION : PRIO_AS_PAGE_FAULT;
        r.mem = on && !r.ex && !tp && !v;
        r.tpr = tp && r.cls != CLASS_PHYSICAL;
        r.wb = r.ex && r.cls == CLASS_PHYSICAL && w && ctrl[CTRL_WRITE_1ST_BIT];
        r.cc = on;
        r.cm = !w;
        return r;
    endfunction

    task automatic acc(input src_t s, input logic [31:0] ad, input logic [1:0] lv,
                       input logic [7:0] at, input logic v, input logic f, input logic w,
                       input logic [3:0] b, input logic om);
        exp_q.push_back(calc(s, ad, 1'b1, lv, at, v, f, w, b, om));
        u_src.send(s, ad, g, 1'b1, lv, at, v, f, w, b);
    endtask

    always @(posedge pclk) begin
        if (res_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                if (e.cc) chk(32'(res_class), 32'(e.cls));
                chk(32'(res_exit), 32'(e.ex));
                chk(32'(res_prio), 32'(e.pr));
                if (e.cm) chk(32'(res_memory_op), 32'(e.mem));
                chk(32'(res_tpr_shadow), 32'(e.tpr));
                chk(32'(res_write_before_exit), 32'(e.wb));
            end
        end
    end

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, {24'h0, ad}, d);
    endtask

    initial begin
        void'($urandom(20));
        {ctrl, prim, pgr, base, g} = {32'h60, 128'h0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, {24'h0, OFS_CTRL}, 32'h0);
        chk(rd, 32'h60);
        wr(OFS_STATUS, 32'hffff_ffff);
        apb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 32'h24, 32'h0);
        chk(32'(err), 32'h1);
        $display("registers done");
        for (int i = 0; i < 8; i++) begin
            wr(OFS_PAGING, i);
            repeat (2) @(posedge pclk);
            #1 chk(32'(pae_active), 32'(i == 3));
        end
        for (int j = 0; j < 4; j++) begin
            wr(OFS_PRIMARY, {j[1], 31'h0});
            wr(OFS_CTRL, 32'h60 | (j[0] << 1));
            repeat (2) @(posedge pclk);
            #1 chk(32'(slt_effective), 32'(j == 3));
        end
        $display("enables done");
        {ctrl, prim, pgr, base} = {32'h63, 32'h8000_0000, 32'h1, 32'h0003_5000};
        wr(OFS_CTRL, ctrl);
        wr(OFS_PAGING, pgr);
        wr(OFS_PAGE_BASE, base); // page kept clear of walk addresses
        for (int k = 0; k < 2; k++) begin
            prim = k == 0 ? 32'h8000_0000 : 32'h0;
            wr(OFS_PRIMARY, prim);
            for (int i = 0; i < 9; i++) begin
                g = $urandom;
                acc(src_t'(i[3:0]), {base[31:12], 12'($urandom)} & 32'hffff_ff7c, 2'h1, 8'h0,
                    1'b0, 1'b0, 1'b0, 4'h4, 1'b0);
            end
        end
        wr(OFS_PRIMARY, (prim = 32'h8000_0000));
        acc(SRC_NO_LINEAR, base + 32'h2000, 2'h1, 8'h0, 1'b0, 1'b0, 1'b0, 4'h4, 1'b0);
        acc(SRC_NO_LINEAR, base + 32'h10, 2'h1, 8'h0, 1'b1, 1'b0, 1'b0, 4'h4, 1'b0);
        acc(SRC_OWN_LINEAR, base + 32'h10, 2'h1, 8'h0, 1'b1, 1'b0, 1'b0, 4'h4, 1'b0);
        $display("classes done");
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CTRL, (ctrl = k ? 32'h63 : 32'h6b));
            acc(SRC_NO_LINEAR, base, LEVEL_1GB, 8'h80, 1'b0, 1'b0, 1'b0, 4'h4, 1'b0);
            acc(SRC_NO_LINEAR, base, LEVEL_2MB, 8'h80, 1'b0, 1'b0, 1'b0, 4'h4, 1'b0);
            acc(SRC_NO_LINEAR, base, LEVEL_2MB, 8'h7f, 1'b0, 1'b0, 1'b0, 4'h4, 1'b0);
        end
        $display("large leaves done");
        wr(OFS_CTRL, (ctrl = 32'h73));
        wr(OFS_ROOT, 32'h1234_5000);
        g = $urandom;
        for (int k = 0; k < 4; k++) begin
            a = base + 32'h1000 * (k + 1);
            acc(SRC_NO_LINEAR, a, 2'h1, 8'h0, 1'b0, 1'b0, 1'b0, 4'h4, 1'b0);
            wr(OFS_PAGE_BASE, (base = a));
            acc(SRC_NO_LINEAR, a, 2'h1, 8'h0, 1'b0, 1'b0, 1'b0, 4'h4, 1'b1);
            wr(OFS_INV_DESC, k[0] ? 32'h1234_5000 : 32'h1234_6000);
            wr(OFS_INV_CMD, k[1] ? 32'h2 : 32'h1);
            acc(SRC_NO_LINEAR, a, 2'h1, 8'h0, 1'b0, 1'b0, 1'b0, 4'h4,
                k == 0);
        end
        $display("stale cache done");
        wr(OFS_CTRL, (ctrl = 32'h67));
        for (int b = 1; b < 6; b++)
            acc(SRC_NO_LINEAR, base | 32'h80, 2'h1, 8'h0, 1'b0, 1'b0, 1'b0, 4'(b), 1'b0);
        acc(SRC_NO_LINEAR, base | 32'h81, 2'h1, 8'h0, 1'b0, 1'b0, 1'b0, 4'h2, 1'b0);
        acc(SRC_NO_LINEAR, base | 32'h80, 2'h1, 8'h0, 1'b0, 1'b1, 1'b0, 4'h4, 1'b0);
        $display("shadow done");
        wr(OFS_CTRL, (ctrl = 32'h03));
        acc(SRC_CTRL_REGION, base, 2'h1, 8'h0, 1'b0, 1'b0, 1'b0, 4'h4, 1'b0);
        wr(OFS_CTRL, (ctrl = 32'h63));
        acc(SRC_SLT_STRUCT, base, 2'h1, 8'h0, 1'b0, 1'b0, 1'b1, 4'h4, 1'b0);
        $display("physical done");
        for (int n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge pclk);
        if (exp_q.size() != 0) error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
